/* File: common/rxf_pkg.sv */
package rxf_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  IDX_HDLC_CTRL     = 8'h10;
  localparam logic [7:0]  IDX_BIT_SUPPRESS  = 8'h11;
  localparam logic [7:0]  IDX_MON_SELECT    = 8'h12;
  localparam logic [7:0]  IDX_SIG_CTRL      = 8'h13;
  localparam logic [7:0]  IDX_T1_CTRL_TWO   = 8'h14;
  localparam int          IDX_STRIDE        = 4;
  localparam logic [7:0]  ADDR_HDLC_CTRL    = 8'(IDX_HDLC_CTRL * IDX_STRIDE);
  localparam logic [7:0]  ADDR_BIT_SUPPRESS = 8'(IDX_BIT_SUPPRESS * IDX_STRIDE);
  localparam logic [7:0]  ADDR_MON_SELECT   = 8'(IDX_MON_SELECT * IDX_STRIDE);
  localparam logic [7:0]  ADDR_SIG_CTRL     = 8'(IDX_SIG_CTRL * IDX_STRIDE);
  localparam logic [7:0]  ADDR_T1_CTRL_TWO  = 8'(IDX_T1_CTRL_TWO * IDX_STRIDE);
  localparam logic [7:0]  ADDR_FORCE_ONES   = 8'h60;
  localparam logic [7:0]  ADDR_MODE         = 8'h64;
  localparam logic [7:0]  ADDR_STATUS       = 8'h68;
  localparam logic [7:0]  ADDR_MONITOR      = 8'h6C;

  // ****************************************
  // Fields, masks and reset values
  // ****************************************
  localparam logic [7:0]  REG_RESET         = 8'h00;
  localparam logic [23:0] FORCE_RESET       = 24'h000000;
  localparam logic [7:0]  HC_MASK           = 8'hBF;
  localparam int          HC_CRC_BIT        = 7;
  localparam int          HC_RESET_BIT      = 6;
  localparam int          HC_MAP_BIT        = 5;
  localparam logic [7:0]  MON_MASK          = 8'h1F;
  localparam logic [7:0]  SIGC_MASK         = 8'h17;
  localparam int          SC_FORCE_BIT      = 4;
  localparam int          SC_FFREEZE_BIT    = 2;
  localparam int          SC_FREEZE_EN_BIT  = 1;
  localparam int          SC_INTEG_BIT      = 0;
  localparam logic [7:0]  T2_MASK           = 8'h1F;
  localparam int          T2_SLC_BIT        = 4;
  localparam int          T2_OOF_MSB        = 3;
  localparam int          T2_OOF_LSB        = 2;
  localparam int          T2_RAI_INTEG_BIT  = 1;
  localparam int          T2_D4RM_BIT       = 0;
  localparam logic [7:0]  MODE_MASK         = 8'h03;
  localparam int          MODE_E1_BIT       = 0;
  localparam int          MODE_ESF_BIT      = 1;
  localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
  localparam logic        HRESP_OKAY        = 1'b0;

  // ****************************************
  // Counts and timing
  // ****************************************
  localparam logic [4:0]  FORCE_CHANNELS    = 5'h18;
  localparam logic [1:0]  SIG_STABLE_MF     = 2'h3;
  localparam logic [1:0]  CAS_ERR_LIMIT     = 2'h2;
  localparam logic [4:0]  OOF_ERR_LIMIT     = 5'h02;
  localparam logic [5:0]  OOF_WIN_4         = 6'h0F;
  localparam logic [5:0]  OOF_WIN_5         = 6'h1F;
  localparam logic [5:0]  OOF_WIN_6         = 6'h3F;
  localparam logic [4:0]  RAI_SET_RUN       = 5'h10;
  localparam logic [4:0]  RAI_CLEAR_MAX     = 5'h0E;
  localparam int          RAI_INTEG_MS      = 200;
  localparam int          CLK_KHZ           = 125000;
  localparam int          RAI_INTEG_CYCLES  = RAI_INTEG_MS * CLK_KHZ;

  typedef enum logic {RXF_CAS_HUNT, RXF_CAS_SYNC} rxf_cas_t;

  function automatic logic [4:0] rxf_ones(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) n = n + {4'h0, v[i]};
    return n;
  endfunction : rxf_ones

endpackage : rxf_pkg

/* File: verilog/rxf_rai_detect.sv */
module rxf_rai_detect #(
  parameter int unsigned INTEG_CYCLES = rxf_pkg::RAI_INTEG_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic clk_en,
  input  wire logic pattern_valid,
  input  wire logic pattern_match,
  input  wire logic integrate,
  output logic      rai_q
);

  // ****************************************
  // Pattern history and raw detection
  // ****************************************
  logic [15:0] hist_q;
  logic        raw_q;
  logic        integ_q;
  logic [31:0] cnt_q;
  logic [4:0]  hits;
  logic        raw_d;
  logic        cnt_done;
  logic        integ_d;

  assign hits     = rxf_pkg::rxf_ones(hist_q);
  assign raw_d    = (hits == rxf_pkg::RAI_SET_RUN) ? 1'b1 :
                    (hits <= rxf_pkg::RAI_CLEAR_MAX) ? 1'b0 : raw_q;
  assign cnt_done = cnt_q > INTEG_CYCLES;
  assign integ_d  = cnt_done ? raw_q : integ_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_q  <= 16'h0000;
      raw_q   <= 1'b0;
      integ_q <= 1'b0;
      cnt_q   <= 32'h00000000;
      rai_q   <= 1'b0;
    end else if (clk_en) begin
      if (pattern_valid) hist_q <= {hist_q[14:0], pattern_match};
      raw_q   <= raw_d;
      integ_q <= integ_d;
      cnt_q   <= (raw_q == integ_q || cnt_done) ? 32'h00000000 : cnt_q + 32'h00000001;
      rai_q   <= integrate ? integ_d : raw_d;
    end
  end

endmodule : rxf_rai_detect

/* File: verilog/rxf_regs.sv */
// The AHB-Lite register port was left to the implementer.
module rxf_regs #(
  parameter int unsigned RAI_INTEG_CYCLES = rxf_pkg::RAI_INTEG_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        frame_start,
  input  wire logic        ch_valid,
  input  wire logic [4:0]  ch_num,
  input  wire logic [7:0]  ch_byte,
  input  wire logic        fdl_valid,
  input  wire logic        fdl_bit,
  input  wire logic        sig_valid,
  input  wire logic [4:0]  sig_chan,
  input  wire logic [3:0]  sig_bits,
  input  wire logic        freeze_request,
  input  wire logic        fbit_valid,
  input  wire logic        fbit_error,
  input  wire logic        cas_mfas_valid,
  input  wire logic        cas_mfas_error,
  input  wire logic        cas_ts16_zero,
  input  wire logic        cas_ts16_prev_one,
  input  wire logic        yellow_bit2_zero,
  input  wire logic        yellow_sbit12,
  input  wire logic        rai_pattern_valid,
  input  wire logic        rai_pattern_match,
  output logic             rx_link_ctrl_reset,
  output logic             crc_to_fifo_enable,
  output logic             hdlc_valid_q,
  output logic [7:0]       hdlc_byte_q,
  output logic [7:0]       hdlc_mask_q,
  output logic             slc_sync_enable,
  output logic             rx_signaling_valid_q,
  output logic [3:0]       rx_signaling_output,
  output logic [3:0]       rx_serial_data_output,
  output logic             sig_change_q,
  output logic [4:0]       sig_change_chan_q,
  output logic             cas_resync_q,
  output logic             frame_loss_q,
  output logic             remote_alarm_q,
  output logic             d4_yellow_q
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0]          hdlc_ctrl_q;
  logic [7:0]          bit_suppress_q;
  logic [7:0]          mon_select_q;
  logic [7:0]          sig_ctrl_q;
  logic [7:0]          t1_ctrl_two_q;
  logic [7:0]          mode_q;
  logic [23:0]         force_ones_q;
  logic [7:0]          monitor_q;
  logic [4:0]          active_chan_q;
  logic                wr_pend_q;
  logic [7:0]          wr_addr_q;
  logic [5:0]          fbit_hist_q;
  logic [1:0]          cas_err_q;
  rxf_pkg::rxf_cas_t   cas_state_q;
  logic [3:0]          rep_q [32];
  logic [3:0]          cand_q [32];
  logic [1:0]          stab_q [32];

  // ****************************************
  // Bus decode
  // ****************************************
  logic        xfer;
  logic        addr_hit_low;
  logic [7:0]  a8;
  logic [31:0] rd_word;
  logic [7:0]  status;
  logic        wr_hc;
  logic        wr_bs;
  logic        wr_ms;
  logic        wr_sc;
  logic        wr_t2;
  logic        wr_md;
  logic        wr_fo;

  assign xfer         = hsel && hready && (htrans == rxf_pkg::HTRANS_NONSEQ);
  assign addr_hit_low = haddr[31:8] == 24'h000000;
  assign a8           = haddr[7:0];
  assign status       = {3'h0, rx_link_ctrl_reset, cas_state_q == rxf_pkg::RXF_CAS_SYNC,
                         d4_yellow_q, frame_loss_q, remote_alarm_q};
  assign rd_word      = !addr_hit_low                      ? 32'h00000000 :
                        (a8 == rxf_pkg::ADDR_HDLC_CTRL)    ? {24'h000000, hdlc_ctrl_q} :
                        (a8 == rxf_pkg::ADDR_BIT_SUPPRESS) ? {24'h000000, bit_suppress_q} :
                        (a8 == rxf_pkg::ADDR_MON_SELECT)   ? {24'h000000, mon_select_q} :
                        (a8 == rxf_pkg::ADDR_SIG_CTRL)     ? {24'h000000, sig_ctrl_q} :
                        (a8 == rxf_pkg::ADDR_T1_CTRL_TWO)  ? {24'h000000, t1_ctrl_two_q} :
                        (a8 == rxf_pkg::ADDR_MODE)         ? {24'h000000, mode_q} :
                        (a8 == rxf_pkg::ADDR_FORCE_ONES)   ? {8'h00, force_ones_q} :
                        (a8 == rxf_pkg::ADDR_STATUS)       ? {24'h000000, status} :
                        (a8 == rxf_pkg::ADDR_MONITOR)      ? {24'h000000, monitor_q} :
                        32'h00000000;
  assign wr_hc = wr_pend_q && (wr_addr_q == rxf_pkg::ADDR_HDLC_CTRL);
  assign wr_bs = wr_pend_q && (wr_addr_q == rxf_pkg::ADDR_BIT_SUPPRESS);
  assign wr_ms = wr_pend_q && (wr_addr_q == rxf_pkg::ADDR_MON_SELECT);
  assign wr_sc = wr_pend_q && (wr_addr_q == rxf_pkg::ADDR_SIG_CTRL);
  assign wr_t2 = wr_pend_q && (wr_addr_q == rxf_pkg::ADDR_T1_CTRL_TWO);
  assign wr_md = wr_pend_q && (wr_addr_q == rxf_pkg::ADDR_MODE);
  assign wr_fo = wr_pend_q && (wr_addr_q == rxf_pkg::ADDR_FORCE_ONES);

  // ****************************************
  // Control decode
  // ****************************************
  logic       e1_mode;
  logic       esf_mode;
  logic       hdlc_busy;
  logic       reset_set;
  logic       reset_d;
  logic [7:0] hdlc_ctrl_d;
  logic       hdlc_fire;
  logic       frozen;
  logic [3:0] cur_rep;
  logic [3:0] cur_cand;
  logic [1:0] cur_stab;
  logic [1:0] stab_d;
  logic       change_ok;
  logic [3:0] rep_d;
  logic [3:0] sig_out_d;
  logic [31:0] force_ext;
  logic       force_hit;
  logic       cas_resync_criteria_select;
  logic       cas_err_ev;
  logic       cas_resync_d;
  logic [5:0] oof_win;
  logic       frame_loss_d;

  assign e1_mode     = mode_q[rxf_pkg::MODE_E1_BIT];
  assign esf_mode    = mode_q[rxf_pkg::MODE_ESF_BIT];
  assign hdlc_busy   = hdlc_ctrl_q[rxf_pkg::HC_RESET_BIT];
  assign reset_set   = wr_hc && hwdata[rxf_pkg::HC_RESET_BIT];
  assign reset_d     = reset_set || (hdlc_busy && !frame_start);
  assign hdlc_ctrl_d = wr_hc ? (hwdata[7:0] & rxf_pkg::HC_MASK) : (hdlc_ctrl_q & rxf_pkg::HC_MASK);
  assign hdlc_fire   = !hdlc_busy && (hdlc_ctrl_q[rxf_pkg::HC_MAP_BIT] ? fdl_valid :
                       (ch_valid && ch_num == active_chan_q));

  assign frozen    = sig_ctrl_q[rxf_pkg::SC_FFREEZE_BIT] ||
                     (sig_ctrl_q[rxf_pkg::SC_FREEZE_EN_BIT] && freeze_request);
  assign cur_rep   = rep_q[sig_chan];
  assign cur_cand  = cand_q[sig_chan];
  assign cur_stab  = stab_q[sig_chan];
  assign stab_d    = (sig_bits != cur_cand) ? 2'h1 :
                     (cur_stab == rxf_pkg::SIG_STABLE_MF) ? cur_stab : cur_stab + 2'h1;
  assign change_ok = (sig_bits != cur_rep) &&
                     (!sig_ctrl_q[rxf_pkg::SC_INTEG_BIT] || stab_d == rxf_pkg::SIG_STABLE_MF);
  assign rep_d     = change_ok ? sig_bits : cur_rep;
  assign sig_out_d = frozen ? cur_rep : sig_bits;
  assign force_ext = {8'h00, force_ones_q};
  assign force_hit = !e1_mode && sig_ctrl_q[rxf_pkg::SC_FORCE_BIT] &&
                     (sig_chan < rxf_pkg::FORCE_CHANNELS) && force_ext[sig_chan];

  assign cas_resync_criteria_select        = e1_mode && sig_ctrl_q[rxf_pkg::SC_FORCE_BIT];
  assign cas_err_ev   = cas_mfas_valid && cas_mfas_error;
  assign cas_resync_d = e1_mode && ((cas_err_ev && cas_err_q == rxf_pkg::CAS_ERR_LIMIT - 2'h1) ||
                        (cas_resync_criteria_select && cas_ts16_zero));

  assign oof_win      = (t1_ctrl_two_q[rxf_pkg::T2_OOF_MSB:rxf_pkg::T2_OOF_LSB] == 2'h0) ? rxf_pkg::OOF_WIN_4 :
                        (t1_ctrl_two_q[rxf_pkg::T2_OOF_MSB:rxf_pkg::T2_OOF_LSB] == 2'h1) ? rxf_pkg::OOF_WIN_5 :
                        rxf_pkg::OOF_WIN_6;
  assign frame_loss_d = rxf_pkg::rxf_ones({10'h000, fbit_hist_q & oof_win}) >= rxf_pkg::OOF_ERR_LIMIT;

  // ****************************************
  // Bus slave and registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout      <= 1'b1;
      hresp          <= rxf_pkg::HRESP_OKAY;
      hrdata         <= 32'h00000000;
      wr_pend_q      <= 1'b0;
      wr_addr_q      <= 8'h00;
      hdlc_ctrl_q    <= rxf_pkg::REG_RESET;
      bit_suppress_q <= rxf_pkg::REG_RESET;
      mon_select_q   <= rxf_pkg::REG_RESET;
      sig_ctrl_q     <= rxf_pkg::REG_RESET;
      t1_ctrl_two_q  <= rxf_pkg::REG_RESET;
      mode_q         <= rxf_pkg::REG_RESET;
      force_ones_q   <= rxf_pkg::FORCE_RESET;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp     <= rxf_pkg::HRESP_OKAY;
      hrdata    <= (xfer && !hwrite) ? rd_word : 32'h00000000;
      wr_pend_q <= xfer && hwrite && addr_hit_low;
      wr_addr_q <= a8;
      hdlc_ctrl_q <= {hdlc_ctrl_d[7], reset_d, hdlc_ctrl_d[5:0]};
      if (wr_bs) bit_suppress_q <= hwdata[7:0];
      if (wr_ms) mon_select_q <= hwdata[7:0] & rxf_pkg::MON_MASK;
      if (wr_sc) sig_ctrl_q <= hwdata[7:0] & rxf_pkg::SIGC_MASK;
      if (wr_t2) t1_ctrl_two_q <= hwdata[7:0] & rxf_pkg::T2_MASK;
      if (wr_md) mode_q <= hwdata[7:0] & rxf_pkg::MODE_MASK;
      if (wr_fo) force_ones_q <= hwdata[23:0];
    end
  end

  // ****************************************
  // HDLC feed and monitor
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_chan_q      <= 5'h00;
      rx_link_ctrl_reset <= 1'b0;
      crc_to_fifo_enable <= 1'b0;
      slc_sync_enable    <= 1'b0;
      hdlc_valid_q       <= 1'b0;
      hdlc_byte_q        <= 8'h00;
      hdlc_mask_q        <= 8'h00;
      monitor_q          <= 8'h00;
    end else if (clk_en) begin
      if (hdlc_busy) active_chan_q <= hdlc_ctrl_q[4:0];
      rx_link_ctrl_reset <= reset_d;
      crc_to_fifo_enable <= hdlc_ctrl_d[rxf_pkg::HC_CRC_BIT];
      slc_sync_enable    <= !e1_mode && t1_ctrl_two_q[rxf_pkg::T2_SLC_BIT];
      hdlc_valid_q       <= hdlc_fire;
      if (hdlc_fire) begin
        hdlc_byte_q <= hdlc_ctrl_q[rxf_pkg::HC_MAP_BIT] ? {7'h00, fdl_bit} : ch_byte;
        hdlc_mask_q <= hdlc_ctrl_q[rxf_pkg::HC_MAP_BIT] ? 8'h01 : ~bit_suppress_q;
      end
      if (ch_valid && ch_num == mon_select_q[4:0]) monitor_q <= ch_byte;
    end
  end

  // ****************************************
  // Signaling path
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 32; i++) begin
        rep_q[i]  <= 4'h0;
        cand_q[i] <= 4'h0;
        stab_q[i] <= 2'h0;
      end
      rx_signaling_valid_q  <= 1'b0;
      rx_signaling_output   <= 4'h0;
      rx_serial_data_output <= 4'h0;
      sig_change_q          <= 1'b0;
      sig_change_chan_q     <= 5'h00;
    end else if (clk_en) begin
      if (sig_valid && !frozen) begin
        rep_q[sig_chan]  <= rep_d;
        cand_q[sig_chan] <= sig_bits;
        stab_q[sig_chan] <= stab_d;
      end
      rx_signaling_valid_q <= sig_valid;
      sig_change_q         <= sig_valid && !frozen && change_ok;
      if (sig_valid) begin
        rx_signaling_output   <= sig_out_d;
        rx_serial_data_output <= force_hit ? 4'hF : sig_out_d;
        sig_change_chan_q     <= sig_chan;
      end
    end
  end

  // ****************************************
  // Framing, CAS and alarms
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fbit_hist_q  <= 6'h00;
      frame_loss_q <= 1'b0;
      cas_err_q    <= 2'h0;
      cas_state_q  <= rxf_pkg::RXF_CAS_HUNT;
      cas_resync_q <= 1'b0;
      d4_yellow_q  <= 1'b0;
    end else if (clk_en) begin
      if (fbit_valid) fbit_hist_q <= {fbit_hist_q[4:0], fbit_error};
      frame_loss_q <= frame_loss_d;
      cas_resync_q <= cas_resync_d;
      if (cas_resync_d) begin
        cas_err_q   <= 2'h0;
        cas_state_q <= rxf_pkg::RXF_CAS_HUNT;
      end else if (cas_mfas_valid) begin
        cas_err_q <= cas_mfas_error ? cas_err_q + 2'h1 : 2'h0;
        case (cas_state_q)
          rxf_pkg::RXF_CAS_HUNT: begin
            if (!cas_mfas_error && (!cas_resync_criteria_select || cas_ts16_prev_one)) cas_state_q <= rxf_pkg::RXF_CAS_SYNC;
          end
          rxf_pkg::RXF_CAS_SYNC: cas_state_q <= rxf_pkg::RXF_CAS_SYNC;
          default: cas_state_q <= rxf_pkg::RXF_CAS_HUNT;
        endcase
      end
      if (!e1_mode && !esf_mode) begin
        d4_yellow_q <= t1_ctrl_two_q[rxf_pkg::T2_D4RM_BIT] ? yellow_sbit12 : yellow_bit2_zero;
      end
    end
  end

  rxf_rai_detect #(
    .INTEG_CYCLES (RAI_INTEG_CYCLES)
  ) u_rai (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .clk_en        (clk_en),
    .pattern_valid (rai_pattern_valid && !e1_mode),
    .pattern_match (rai_pattern_match),
    .integrate     (esf_mode && t1_ctrl_two_q[rxf_pkg::T2_RAI_INTEG_BIT]),
    .rai_q         (remote_alarm_q)
  );

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_hdlc_reset_done: assert property (clk_en && hdlc_busy && frame_start && !reset_set |=> !hdlc_busy)
    else $error("HDLC reset not cleared at frame start");
  a_hdlc_chan_hold: assert property (clk_en && !hdlc_busy |=> active_chan_q == $past(active_chan_q))
    else $error("HDLC channel changed without reset");
  a_hdlc_fdl_map: assert property (clk_en && hdlc_fire && hdlc_ctrl_q[rxf_pkg::HC_MAP_BIT]
                                   |=> hdlc_valid_q && hdlc_mask_q == 8'h01)
    else $error("FDL mapping not applied");
  a_hdlc_suppress: assert property (clk_en && hdlc_fire && !hdlc_ctrl_q[rxf_pkg::HC_MAP_BIT]
                                    |=> hdlc_mask_q == ~$past(bit_suppress_q))
    else $error("Suppress mask wrong");
  a_monitor_copy: assert property (clk_en && ch_valid && ch_num == mon_select_q[4:0]
                                   |=> monitor_q == $past(ch_byte))
    else $error("Monitor byte not captured");
  a_force_ones: assert property (clk_en && sig_valid && force_hit
                                 |=> rx_serial_data_output == 4'hF && rx_signaling_output == $past(sig_out_d))
    else $error("Force ones not applied");
  a_freeze_hold: assert property (clk_en && sig_valid && sig_ctrl_q[rxf_pkg::SC_FFREEZE_BIT]
                                  |=> rx_signaling_output == $past(cur_rep))
    else $error("Forced freeze not holding");
  a_no_freeze: assert property (clk_en && sig_valid && sig_ctrl_q[2:1] == 2'h0
                                |=> rx_signaling_output == $past(sig_bits))
    else $error("Signaling frozen while disabled");
  a_cas_zero_resync: assert property (clk_en && cas_resync_criteria_select && cas_ts16_zero |=> cas_resync_q)
    else $error("Missing resync on zero slot 16");
  a_unmapped_zero: assert property (clk_en && xfer && !hwrite && !addr_hit_low |=> hrdata == 32'h00000000)
    else $error("Unmapped read not zero");

endmodule : rxf_regs

/* File: verif/rxf_line_model.sv */
module rxf_line_model (
  input  wire logic  hclk,
  output logic       frame_start, ch_valid, fdl_valid, fdl_bit, sig_valid, freeze_request, fbit_valid,
  output logic       fbit_error, cas_mfas_valid, cas_mfas_error, cas_ts16_zero, cas_ts16_prev_one,
  output logic       yellow_bit2_zero, yellow_sbit12, rai_pattern_valid, rai_pattern_match,
  output logic [4:0] ch_num, sig_chan,
  output logic [7:0] ch_byte,
  output logic [3:0] sig_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Framer stream source, idle strobes low
  // ****************************************
  initial begin
    {frame_start, ch_valid, fdl_valid, fdl_bit, sig_valid, freeze_request, fbit_valid, fbit_error} = '0;
    {cas_mfas_valid, cas_mfas_error, cas_ts16_zero, cas_ts16_prev_one, yellow_bit2_zero} = '0;
    {yellow_sbit12, rai_pattern_valid, rai_pattern_match, ch_num, sig_chan, ch_byte, sig_bits} = '0;
  end
  task automatic frame();
    @(posedge hclk) frame_start <= 1'b1;
    @(posedge hclk) frame_start <= 1'b0;
  endtask : frame
  task automatic sig(input logic [4:0] c, input logic [3:0] b, input logic f);
    @(posedge hclk) {sig_valid, freeze_request, sig_chan, sig_bits} <= {1'b1, f, c, b};
    @(posedge hclk) {sig_valid, freeze_request, sig_chan, sig_bits} <= {2'h0, ~c, ~b};
  endtask : sig
  task automatic chan(input logic [4:0] n, input logic [7:0] b);
    @(posedge hclk) {ch_valid, fdl_valid, fdl_bit, ch_num, ch_byte} <= {2'h3, b[0], n, b};
    @(posedge hclk) {ch_valid, fdl_valid, fdl_bit, ch_num, ch_byte} <= {2'h0, ~b[0], ~n, ~b};
  endtask : chan
  task automatic strobe(input logic [4:0] v);
    @(posedge hclk) {rai_pattern_valid, rai_pattern_match, cas_mfas_valid, cas_mfas_error, cas_ts16_zero} <= v;
    @(posedge hclk) {rai_pattern_valid, rai_pattern_match, cas_mfas_valid, cas_mfas_error, cas_ts16_zero} <= 5'h00;
  endtask : strobe
  task automatic fbit(input logic e);
    @(posedge hclk) {fbit_valid, fbit_error} <= {1'b1, e};
    @(posedge hclk) {fbit_valid, fbit_error} <= {1'b0, ~e};
  endtask : fbit
endmodule : rxf_line_model

/* File: verif/rx_framer_control_regs_test.sv */
module rx_framer_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_link_ctrl_reset, frame_loss_q;
  logic        frame_start, ch_valid, fdl_valid, fdl_bit, sig_valid, freeze_request, fbit_valid;
  logic        fbit_error, cas_mfas_valid, cas_mfas_error, cas_ts16_zero, cas_ts16_prev_one;
  logic        yellow_bit2_zero, yellow_sbit12, rai_pattern_valid, rai_pattern_match;
  logic        crc_to_fifo_enable, hdlc_valid_q, slc_sync_enable, rx_signaling_valid_q, sig_change_q;
  logic        cas_resync_q, remote_alarm_q;
  logic [1:0]  htrans;
  logic [3:0]  sig_bits, rx_signaling_output, rx_serial_data_output;
  logic [4:0]  ch_num, sig_chan, sig_change_chan_q;
  logic [7:0]  ch_byte, hdlc_byte_q, hdlc_mask_q;
  logic [31:0] haddr, hwdata, hrdata, rd, sig_view;
  int          num_errors, samples_checked;
  localparam logic [7:0] RA [8] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h60, 8'h64, 8'h7C};
  localparam logic [7:0] RM [5] = '{8'hBF, 8'hBF, 8'h1F, 8'h17, 8'h1F};
  assign sig_view = {21'h0, rx_signaling_valid_q, sig_change_chan_q, sig_change_q, rx_signaling_output};
  rxf_regs #(.RAI_INTEG_CYCLES(50)) rxf_regs_i (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .frame_start, .ch_valid,
    .ch_num, .ch_byte, .fdl_valid, .fdl_bit, .sig_valid, .sig_chan, .sig_bits, .freeze_request, .fbit_valid,
    .fbit_error, .cas_mfas_valid, .cas_mfas_error, .cas_ts16_zero, .cas_ts16_prev_one, .yellow_bit2_zero,
    .yellow_sbit12, .rai_pattern_valid, .rai_pattern_match, .rx_link_ctrl_reset, .crc_to_fifo_enable,
    .hdlc_valid_q, .hdlc_byte_q, .hdlc_mask_q, .slc_sync_enable, .rx_signaling_valid_q,
    .rx_signaling_output, .rx_serial_data_output, .sig_change_q, .sig_change_chan_q, .cas_resync_q,
    .frame_loss_q, .remote_alarm_q, .d4_yellow_q());
  rxf_line_model line_i (.hclk, .frame_start, .ch_valid, .fdl_valid, .fdl_bit, .sig_valid, .freeze_request,
    .fbit_valid, .fbit_error, .cas_mfas_valid, .cas_mfas_error, .cas_ts16_zero, .cas_ts16_prev_one,
    .yellow_bit2_zero, .yellow_sbit12, .rai_pattern_valid, .rai_pattern_match, .ch_num, .sig_chan, .ch_byte,
    .sig_bits);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      print_verdict();
    end
  endtask : wait_ready
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h000000, a, rxf_pkg::HTRANS_NONSEQ, w};
    wait_ready();
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    wait_ready();
    rd = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, num_errors, samples_checked} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (RA[i]) begin
      bus(RA[i], 1'b0, 32'h0);
      chk(rd, 32'h0);
    end
    foreach (RM[i]) begin
      bus(RA[i], 1'b1, 32'hFFFFFFBF);
      bus(RA[i], 1'b0, 32'h0);
      chk(rd, {24'h0, RM[i]});
      bus(RA[i], 1'b1, 32'h0);
    end
    $display("test registers done");
    bus(8'h40, 1'b1, 32'h45);
    bus(8'h40, 1'b0, 32'h0);
    chk({rd[31:1], rx_link_ctrl_reset}, 32'h45);
    line_i.frame();
    bus(8'h40, 1'b0, 32'h0);
    chk({rd[31:1], rx_link_ctrl_reset}, 32'h04);
    $display("test link reset done");
    bus(8'h44, 1'b1, 32'h81);
    bus(8'h48, 1'b1, 32'h05);
    bus(8'h40, 1'b1, 32'h06);
    line_i.chan(5'h05, 8'h3C);
    @(posedge hclk);
    chk({crc_to_fifo_enable, hdlc_valid_q, hdlc_byte_q, hdlc_mask_q}, 32'h13C7E);
    bus(8'h6C, 1'b0, 32'h0);
    chk(rd, 32'h3C);
    bus(8'h40, 1'b1, 32'hA5);
    line_i.chan(5'h09, 8'h3D);
    @(posedge hclk);
    chk({crc_to_fifo_enable, hdlc_valid_q, hdlc_byte_q, hdlc_mask_q}, 32'h30101);
    $display("test link feed done");
    bus(8'h60, 1'b1, 32'h1);
    bus(8'h4C, 1'b1, 32'h10);
    line_i.sig(5'h00, 4'h5, 1'b0);
    @(posedge hclk);
    chk({rx_serial_data_output, rx_signaling_output}, 32'hF5);
    line_i.sig(5'h01, 4'h5, 1'b0);
    @(posedge hclk);
    chk({rx_serial_data_output, rx_signaling_output}, 32'h55);
    $display("test force ones done");
    bus(8'h4C, 1'b1, 32'h02);
    line_i.sig(5'h01, 4'hA, 1'b1);
    @(posedge hclk);
    chk(sig_view, 32'h425);
    line_i.sig(5'h01, 4'hA, 1'b0);
    @(posedge hclk);
    chk(sig_view, 32'h43A);
    bus(8'h4C, 1'b1, 32'h01);
    for (int k = 0; k < 4; k++) begin
      if (k == 3) bus(8'h4C, 1'b1, 32'h04);
      line_i.sig(5'h01, k < 3 ? 4'h3 : 4'h6, 1'b0);
      @(posedge hclk);
      chk(sig_view, k == 2 ? 32'h433 : 32'h423);
    end
    $display("test signaling done");
    for (int k = 0; k < 18; k++) begin
      line_i.strobe({1'b1, k < 16, 3'h0});
      repeat (2) @(posedge hclk);
      if (k > 13) chk({31'h0, remote_alarm_q}, {31'h0, k == 15 || k == 16});
    end
    $display("test remote alarm done");
    for (int c = 0; c < 4; c++) begin
      bus(8'h50, 1'b1, 32'(c * 4 + 16));
      repeat (6) line_i.fbit(1'b0);
      line_i.fbit(1'b1);
      repeat ((c > 2 ? 2 : c) + 3) line_i.fbit(1'b0);
      line_i.fbit(1'b1);
      repeat (3) @(posedge hclk);
      chk({30'h0, slc_sync_enable, frame_loss_q}, 32'h2);
      repeat ((c > 2 ? 2 : c) + 2) line_i.fbit(1'b0);
      line_i.fbit(1'b1);
      repeat (3) @(posedge hclk);
      chk({30'h0, slc_sync_enable, frame_loss_q}, 32'h3);
    end
    $display("test frame loss done");
    bus(8'h64, 1'b1, 32'h1);
    bus(8'h4C, 1'b1, 32'h0);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) bus(8'h4C, 1'b1, 32'h10);
      line_i.strobe({2'h0, k < 2, k < 2, k == 2});
      @(posedge hclk);
      chk({31'h0, cas_resync_q}, {31'h0, k > 0});
    end
    $display("test resync done");
    print_verdict();
  end
endmodule : rx_framer_control_regs_test
